// ### src/adc_port_pkg.sv
// constants, register map and state codes of the framed serial port
package adc_port_pkg;

  // ---------------------------------------------------------------------
  // word and counter widths
  // ---------------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CNT_W     = 5;
  localparam int ADDR_W    = 4;

  // ---------------------------------------------------------------------
  // register bus offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK   = 4'h1;
  localparam logic [3:0] OFS_CTRL   = 4'h2;
  localparam logic [3:0] OFS_CALIB  = 4'h3;
  localparam logic [3:0] OFS_RESULT = 4'h4;

  // ---------------------------------------------------------------------
  // control word fields
  // ---------------------------------------------------------------------
  localparam int         MODE_MSB          = 23;
  localparam int         MODE_LSB          = 21;
  localparam logic [2:0] MODE_NORMAL       = 3'h0;
  localparam int         CTRL_UNIPOLAR_BIT = 12;
  localparam int         CTRL_EXC2_BIT     = 14;

  // ---------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------
  localparam logic [23:0] CTRL_RESET   = 24'h000000;
  localparam logic [23:0] CALIB_RESET  = 24'h000000;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [3:0]  MASK_RESET   = 4'h0;
  localparam logic [3:0]  STATUS_RESET = 4'h0;

  // ---------------------------------------------------------------------
  // event bits of status and mask
  // ---------------------------------------------------------------------
  localparam int EV_BITS   = 4;
  localparam int EV_RESULT = 0;
  localparam int EV_CAL    = 1;
  localparam int EV_WRITE  = 2;
  localparam int EV_READ   = 3;

  // ---------------------------------------------------------------------
  // synchronised pin positions and their reset levels
  // ---------------------------------------------------------------------
  localparam int         SYNC_N     = 7;
  localparam int         SY_SCLK    = 0;
  localparam int         SY_BIDIR_SERIAL_LINE   = 1;
  localparam int         SY_WFS     = 2;
  localparam int         SY_RFS     = 3;
  localparam int         SY_SEL     = 4;
  localparam int         SY_MODE    = 5;
  localparam int         SY_STBY    = 6;
  localparam logic [6:0] SYNC_RESET = 7'h4D;

  // ---------------------------------------------------------------------
  // self-clocking shift clock timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int DIV_W         = 4;

  // ---------------------------------------------------------------------
  // frame states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } port_state_e;

endpackage

// ### src/shift_if.sv
// control and data carrier between the port and its word shifter
interface shift_if;
  import adc_port_pkg::*;

  logic                 clear;
  logic                 load;
  logic [WORD_BITS-1:0] load_word;
  logic                 shift_en;
  logic                 bit_in;
  logic [WORD_BITS-1:0] word;
  logic [CNT_W-1:0]     count;

  modport ctl (output clear, load, load_word, shift_en, bit_in,
               input word, count);
  modport sh  (input clear, load, load_word, shift_en, bit_in,
               output word, count);
endinterface

// ### src/pin_sync.sv
// three-stage synchroniser with agreement filter for outside pins
module pin_sync
  import adc_port_pkg::*;
#(
  parameter int              N       = SYNC_N,
  parameter logic [SYNC_N-1:0] RST_VAL = SYNC_RESET
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [N-1:0] pin_async,
  output logic      [N-1:0] pin_stable
);

  // ---------------------------------------------------------------------
  // one chain per pin
  // ---------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic stable_ff;
      logic nxt_stable;

      // change is taken once the second and third stage agree
      always_comb
      begin
        nxt_stable = (s2_ff == s3_ff) ? s2_ff : stable_ff;
      end

      // stage registers; the first stage feeds only the second
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          s1_ff     <= RST_VAL[i];
          s2_ff     <= RST_VAL[i];
          s3_ff     <= RST_VAL[i];
          stable_ff <= RST_VAL[i];
        end
        else
        begin
          s1_ff     <= pin_async[i];
          s2_ff     <= s1_ff;
          s3_ff     <= s2_ff;
          stable_ff <= nxt_stable;
        end
      end

      assign pin_stable[i] = stable_ff;
    end
  endgenerate

endmodule // pin_sync

// ### src/word_shifter.sv
// msb-first word shifter with a bit counter that stops at full
module word_shifter
  import adc_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  shift_if.sh      port
);

  logic [WORD_BITS-1:0] word_ff;
  logic [WORD_BITS-1:0] nxt_word;
  logic [CNT_W-1:0]     count_ff;
  logic [CNT_W-1:0]     nxt_count;

  // ---------------------------------------------------------------------
  // next word and count
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_word  = word_ff;
    nxt_count = count_ff;
    if (port.clear)
    begin
      nxt_word  = '0;
      nxt_count = '0;
    end
    else if (port.load)
    begin
      nxt_word  = port.load_word;
      nxt_count = '0;
    end
    // no shift past a full word
    else if (port.shift_en && (count_ff < CNT_W'(WORD_BITS)))
    begin
      nxt_word  = {word_ff[WORD_BITS-2:0], port.bit_in};
      nxt_count = count_ff + CNT_W'(1);
    end
  end

  // registers only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      word_ff  <= '0;
      count_ff <= '0;
    end
    else
    begin
      word_ff  <= nxt_word;
      count_ff <= nxt_count;
    end
  end

  assign port.word  = word_ff;
  assign port.count = count_ff;

endmodule // word_shifter

// ### src/adc_framed_serial_port.sv
// framed bidirectional serial port of a sigma-delta converter
//
// Behaviour
// - self-clocking: shift clock driven only after write or read frame sync low.
// - read frame sync low enables shift clock (self) and data output.
// - external clocking: data driver enabled only after read sync low.
// - result_ready_n falls when a new result word is available.
// - result_ready_n returns high after a full result word shifted out.
// - result_ready_n also falls when calibration has finished.
// - result read drives data only while a result is pending.
// - write bits sampled on rising shift clock while write sync low.
// - result plain binary if unipolar, offset binary if bipolar.
// - data line writes control/calibration, reads those and result.
// - second excitation current follows a control register bit.
// - clock-mode pin high selects self clocking, low external.
// - control register loaded only after a complete 24-bit frame.
// - shift clock pulses past the 24th in a frame are ignored.
// - standby low halts the frame sequencer and the result and calibration events.
module adc_framed_serial_port
  import adc_port_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        sclk_in,
  output logic                             sclk_out,
  output logic                             sclk_oe,
  input  wire logic                        bidir_serial_line_in,
  output logic                             bidir_serial_line_out,
  output logic                             bidir_serial_line_oe,
  input  wire logic                        write_frame_sync_n,
  input  wire logic                        read_frame_sync_n,
  input  wire logic                        clk_mode,
  input  wire logic                        reg_sel,
  input  wire logic                        standby_n,
  output logic                             result_ready_n,
  output logic                             second_excitation_current,
  input  wire logic                        result_valid,
  input  wire logic [adc_port_pkg::WORD_BITS-1:0] result_data,
  input  wire logic                        cal_done,
  input  wire logic [adc_port_pkg::ADDR_W-1:0]    bus_addr,
  input  wire logic [adc_port_pkg::WORD_BITS-1:0] bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic      [adc_port_pkg::WORD_BITS-1:0] bus_rdata,
  output logic                             irq
);
  import adc_port_pkg::*;

  // ---------------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------------
  logic [SYNC_N-1:0] pin;

  pin_sync #(
    .N       (SYNC_N),
    .RST_VAL (SYNC_RESET)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_async ({standby_n, clk_mode, reg_sel, read_frame_sync_n,
                 write_frame_sync_n, bidir_serial_line_in, sclk_in}),
    .pin_stable(pin)
  );

  // ---------------------------------------------------------------------
  // word shifter
  // ---------------------------------------------------------------------
  shift_if sh ();

  word_shifter u_shift (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (sh)
  );

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  port_state_e          state_ff;
  port_state_e          nxt_state;
  logic [DIV_W-1:0]     div_ff;
  logic [DIV_W-1:0]     nxt_div;
  logic                 sclk_ff;
  logic                 nxt_sclk;
  logic                 prev_sclk_ff;
  logic                 prev_wfs_ff;
  logic                 prev_rfs_ff;
  logic                 drive_ff;
  logic                 nxt_drive;
  logic                 rd_result_ff;
  logic                 nxt_rd_result;

  logic [WORD_BITS-1:0] ctrl_ff;
  logic [WORD_BITS-1:0] nxt_ctrl;
  logic [WORD_BITS-1:0] calib_ff;
  logic [WORD_BITS-1:0] nxt_calib;
  logic [WORD_BITS-1:0] result_ff;
  logic [WORD_BITS-1:0] nxt_result;
  logic                 rdy_n_ff;
  logic                 nxt_rdy_n;
  logic [EV_BITS-1:0]   status_ff;
  logic [EV_BITS-1:0]   nxt_status;
  logic [EV_BITS-1:0]   mask_ff;
  logic [EV_BITS-1:0]   nxt_mask;
  logic [WORD_BITS-1:0] rdata_ff;
  logic [WORD_BITS-1:0] nxt_rdata;

  // decoded conditions
  logic                 active;
  logic                 self_mode;
  logic                 normal_mode;
  logic                 full;
  logic                 rise;
  logic                 int_rise;
  logic                 commit;
  logic                 read_done;
  logic [WORD_BITS-1:0] read_word;
  logic                 read_ok;
  logic [EV_BITS-1:0]   events;
  logic [EV_BITS-1:0]   w1c;

  // bus address match, used by the write decoders
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0]        ofs);
    hit = (a == ofs);
  endfunction

  // ---------------------------------------------------------------------
  // common decodes
  // ---------------------------------------------------------------------
  // standby low halts the frame sequencer and the result and calibration events
  assign active      = pin[SY_STBY];
  // clock-mode pin selects who makes the shift clock
  assign self_mode   = pin[SY_MODE];
  assign normal_mode = (ctrl_ff[MODE_MSB:MODE_LSB] == MODE_NORMAL);
  assign full        = (sh.count == CNT_W'(WORD_BITS));

  // read source picks control, calibration or result
  always_comb
  begin
    read_word = ctrl_ff;
    read_ok   = 1'b1;
    if (pin[SY_SEL])
    begin
      if (normal_mode)
      begin
        read_word = result_ff;
        read_ok   = ~rdy_n_ff;
      end
      else
      begin
        read_word = calib_ff;
      end
    end
  end

  // ---------------------------------------------------------------------
  // frame sequencer and self clock divider
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_div       = div_ff;
    nxt_sclk      = sclk_ff;
    nxt_drive     = drive_ff;
    nxt_rd_result = rd_result_ff;
    int_rise      = 1'b0;
    commit        = 1'b0;
    read_done     = 1'b0;
    sh.clear      = 1'b0;
    sh.load       = 1'b0;
    sh.load_word  = read_word;
    sh.shift_en   = 1'b0;
    sh.bit_in     = 1'b0;

    // clock toggles only inside a frame and stops at full word
    if (self_mode && (state_ff != ST_IDLE) && !full)
    begin
      if (div_ff == DIV_W'(SCLK_HALF_CYC - 1))
      begin
        nxt_div  = '0;
        nxt_sclk = ~sclk_ff;
        int_rise = ~sclk_ff;
      end
      else
      begin
        nxt_div = div_ff + DIV_W'(1);
      end
    end
    rise = self_mode ? int_rise : (pin[SY_SCLK] & ~prev_sclk_ff);

    if (!active)
    begin
      nxt_state = ST_IDLE;
      nxt_div   = '0;
      nxt_sclk  = 1'b1;
      nxt_drive = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          // write frame opens on the falling sync edge
          if (prev_wfs_ff && !pin[SY_WFS])
          begin
            sh.clear  = 1'b1;
            nxt_state = ST_WRITE;
          end
          // read frame opens on the falling sync edge
          else if (prev_rfs_ff && !pin[SY_RFS])
          begin
            sh.load       = 1'b1;
            nxt_drive     = read_ok;
            nxt_rd_result = pin[SY_SEL] & normal_mode;
            nxt_state     = ST_READ;
          end
        end
        ST_WRITE:
        begin
          // sample data at each rising shift clock
          if (rise && !full)
          begin
            sh.shift_en = 1'b1;
            sh.bit_in   = pin[SY_BIDIR_SERIAL_LINE];
          end
          if (pin[SY_WFS])
          begin
            // only a full word is committed
            commit    = full;
            nxt_state = ST_IDLE;
            nxt_div   = '0;
            nxt_sclk  = 1'b1;
          end
        end
        ST_READ:
        begin
          // next bit moves up after the host took the current one
          if (rise && !full)
          begin
            sh.shift_en = 1'b1;
            read_done   = rd_result_ff && drive_ff &&
                          (sh.count == CNT_W'(WORD_BITS - 1));
          end
          // driver released once read sync is high
          if (pin[SY_RFS])
          begin
            nxt_state = ST_IDLE;
            nxt_drive = 1'b0;
            nxt_div   = '0;
            nxt_sclk  = 1'b1;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // frame registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_ff     <= ST_IDLE;
      div_ff       <= '0;
      sclk_ff      <= 1'b1;
      prev_sclk_ff <= 1'b1;
      prev_wfs_ff  <= 1'b1;
      prev_rfs_ff  <= 1'b1;
      drive_ff     <= 1'b0;
      rd_result_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      div_ff       <= nxt_div;
      sclk_ff      <= nxt_sclk;
      prev_sclk_ff <= pin[SY_SCLK];
      prev_wfs_ff  <= pin[SY_WFS];
      prev_rfs_ff  <= pin[SY_RFS];
      drive_ff     <= nxt_drive;
      rd_result_ff <= nxt_rd_result;
    end
  end

  // ---------------------------------------------------------------------
  // port registers, ready flag, status and bus
  // ---------------------------------------------------------------------
  assign events[EV_RESULT] = active & result_valid;
  assign events[EV_CAL]    = active & cal_done;
  assign events[EV_WRITE]  = commit;
  assign events[EV_READ]   = read_done;
  assign w1c = (bus_wr && hit(bus_addr, OFS_STATUS)) ?
               bus_wdata[EV_BITS-1:0] : '0;

  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_calib  = calib_ff;
    nxt_result = result_ff;
    nxt_rdy_n  = rdy_n_ff;
    nxt_mask   = mask_ff;
    nxt_rdata  = '0;

    // committed word lands by register select
    if (commit && !pin[SY_SEL])
    begin
      nxt_ctrl = sh.word;
    end
    if (commit && pin[SY_SEL] && !normal_mode)
    begin
      nxt_calib = sh.word;
    end
    // bipolar results flip the sign bit into offset binary
    if (events[EV_RESULT])
    begin
      nxt_result = ctrl_ff[CTRL_UNIPOLAR_BIT] ? result_data :
                   {~result_data[WORD_BITS-1], result_data[WORD_BITS-2:0]};
    end
    // ready returns high after a full result word
    if (read_done)
    begin
      nxt_rdy_n = 1'b1;
    end
    // ready falls on a new result; also on calibration done
    if (events[EV_RESULT] || events[EV_CAL])
    begin
      nxt_rdy_n = 1'b0;
    end
    // sticky status, set wins over clear
    nxt_status = (status_ff & ~w1c) | events;
    if (bus_wr && hit(bus_addr, OFS_MASK))
    begin
      nxt_mask = bus_wdata[EV_BITS-1:0];
    end
    // read data for the cycle after the strobe
    if (bus_rd)
    begin
      case (bus_addr)
        OFS_STATUS: nxt_rdata = {{(WORD_BITS-EV_BITS){1'b0}}, status_ff};
        OFS_MASK:   nxt_rdata = {{(WORD_BITS-EV_BITS){1'b0}}, mask_ff};
        OFS_CTRL:   nxt_rdata = ctrl_ff;
        OFS_CALIB:  nxt_rdata = calib_ff;
        OFS_RESULT: nxt_rdata = result_ff;
        default:    nxt_rdata = '0;
      endcase
    end
  end

  // register file
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_ff   <= CTRL_RESET;
      calib_ff  <= CALIB_RESET;
      result_ff <= RESULT_RESET;
      rdy_n_ff  <= 1'b1;
      status_ff <= STATUS_RESET;
      mask_ff   <= MASK_RESET;
      rdata_ff  <= '0;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      calib_ff  <= nxt_calib;
      result_ff <= nxt_result;
      rdy_n_ff  <= nxt_rdy_n;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // shift clock driven in self mode inside a frame
  assign sclk_out  = sclk_ff;
  assign sclk_oe   = self_mode & active & (state_ff != ST_IDLE);
  // data driver enabled only inside a read frame
  assign bidir_serial_line_out = sh.word[WORD_BITS-1];
  assign bidir_serial_line_oe  = drive_ff;
  assign result_ready_n = rdy_n_ff;
  // second excitation current from control bit
  assign second_excitation_current = ctrl_ff[CTRL_EXC2_BIT];
  assign bus_rdata = rdata_ff;
  assign irq       = |(status_ff & mask_ff);

endmodule // adc_framed_serial_port

// ### dv/adc_port_chk.sv
// assertion checker on the pins of the framed serial port
module adc_port_chk
  import adc_port_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 sclk_oe,
  input wire logic                 bidir_serial_line_oe,
  input wire logic                 write_frame_sync_n,
  input wire logic                 read_frame_sync_n,
  input wire logic                 clk_mode,
  input wire logic                 reg_sel,
  input wire logic                 standby_n,
  input wire logic                 result_ready_n,
  input wire logic                 second_excitation_current,
  input wire logic                 result_valid,
  input wire logic                 cal_done,
  input wire logic                 bus_rd,
  input wire logic [WORD_BITS-1:0] bus_rdata,
  input wire logic                 irq
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_data_hiz: assert property (
    read_frame_sync_n [*8] |-> !bidir_serial_line_oe)
    else $error("data driven outside a read frame");
  chk_clk_in_frame: assert property (
    (write_frame_sync_n && read_frame_sync_n) [*8] |-> !sclk_oe)
    else $error("shift clock driven outside a frame");
  chk_ext_mode: assert property (
    !clk_mode [*8] |-> !sclk_oe)
    else $error("shift clock driven in external mode");
  chk_ready_fall: assert property (
    result_valid && standby_n |-> ##[1:2] !result_ready_n)
    else $error("ready not low after new result");
  chk_cal_ready: assert property (
    cal_done && standby_n |-> ##[1:2] !result_ready_n)
    else $error("ready not low after calibration");
  chk_read_pend: assert property (
    $rose(bidir_serial_line_oe) && reg_sel |-> !result_ready_n)
    else $error("result driven with no result pending");
  chk_stby_quiet: assert property (
    !standby_n [*8] |-> !bidir_serial_line_oe && !sclk_oe)
    else $error("port active in standby");
  chk_exc_frame: assert property (
    $changed(second_excitation_current) |-> write_frame_sync_n)
    else $error("excitation changed inside a write frame");
  chk_rdata_one: assert property (
    !bus_rd |=> bus_rdata == '0)
    else $error("read data outside its cycle");

  cover property (!result_ready_n ##1 result_ready_n);
  cover property ($rose(bidir_serial_line_oe));
  cover property ($rose(sclk_oe));
  cover property ($rose(irq));
endmodule // adc_port_chk

bind adc_framed_serial_port adc_port_chk chk_u (.*);

// ### dv/host_model.sv
// host side of the serial link in external clocking mode
module host_model
(
  output logic    sclk,
  output logic    wfs_n,
  output logic    rfs_n,
  output logic    hd,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link: clock high, both syncs high
  initial
  begin
    sclk  = 1;
    wfs_n = 1;
    rfs_n = 1;
    hd    = 0;
  end

  // sync falls before the first bit
  task automatic frame(input bit rd, input int n,
                       input logic [23:0] w, output logic [23:0] r);
    #3;
    if (rd)
      rfs_n = 0;
    else
      wfs_n = 0;
    #120;
    // bit set while clock low, taken at the rise
    for (int i = 0; i < n; i++)
    begin
      sclk = 0;
      hd   = w[23-(i%24)];
      #40;
      r    = {r[22:0], line};
      sclk = 1;
      #40;
    end
    #80;
    rfs_n = 1;
    wfs_n = 1;
    hd    = ~hd; // released line shows the inverse
    #200;
  endtask

  // read sync alone, for frames the device clocks itself
  task automatic rsync(input logic lvl);
    #3;
    rfs_n = lvl;
  endtask
endmodule // host_model

// ### dv/adc_framed_serial_port_tb.sv
// self-checking bench of the framed serial port
module adc_framed_serial_port_tb;
  import adc_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 0, rst = 1, clk_mode = 0, reg_sel = 0, standby_n = 1;
  logic result_valid = 0, cal_done = 0, bus_wr = 0, bus_rd = 0;
  logic [3:0]  bus_addr = '0;
  logic [23:0] bus_wdata = '0, result_data = '0, bus_rdata, v, w, ctrl_m;
  logic sclk_out, sclk_oe, bidir_serial_line_out, bidir_serial_line_oe, result_ready_n, exc, irq;
  logic h_sclk, h_wfs_n, h_rfs_n, h_d;
  int oe_cnt = 0;
  wire logic sclk_pin = sclk_oe ? sclk_out : h_sclk;
  wire logic sd_pin = bidir_serial_line_oe ? bidir_serial_line_out : h_d;
  int n_fail = 0;
  int tests_run = 0;
  logic [23:0] res_q[$];

  adc_framed_serial_port dut_u (.sclk_in(sclk_pin), .bidir_serial_line_in(sd_pin),
    .write_frame_sync_n(h_wfs_n), .read_frame_sync_n(h_rfs_n),
    .second_excitation_current(exc), .*);
  host_model hst_u (.sclk(h_sclk), .wfs_n(h_wfs_n), .rfs_n(h_rfs_n),
    .hd(h_d), .line(sd_pin));

  // system clock and data-driver watch
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (bidir_serial_line_oe)
      oe_cnt <= oe_cnt + 1;

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1;
    @(posedge clk_sys);
    bus_wr    <= 0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1;
    @(posedge clk_sys);
    bus_rd   <= 0;
    #1 check(bus_rdata, e);
  endtask

  task automatic ser(input bit r, input logic s, input int n,
                     input logic [23:0] d);
    @(posedge clk_sys);
    reg_sel <= s;
    repeat (8) @(posedge clk_sys);
    hst_u.frame(r, n, d, v);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h3CE6D8CC));
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    repeat (8) @(posedge clk_sys);
    rd(OFS_CTRL, CTRL_RESET);
    rd(4'hF, 24'h0);
    wr(OFS_MASK, 24'hF);
    for (int i = 0; i < 2; i++)
    begin
      w = {3'h0, 8'($urandom), 1'(i), 12'($urandom)};
      ser(0, 0, 24, w);
      ctrl_m = w;
      rd(OFS_CTRL, ctrl_m);
      check({23'h0, exc}, {23'h0, w[CTRL_EXC2_BIT]});
      ser(0, 0, 23, ~w);
      rd(OFS_CTRL, ctrl_m);
      ser(0, 0, 26, w ^ 24'h0FEFFF);
      ctrl_m = w ^ 24'h0FEFFF;
      rd(OFS_CTRL, ctrl_m);
      ser(1, 0, 24, 24'h0);
      check(v, ctrl_m);
      w = 24'($urandom);
      res_q.push_back(ctrl_m[CTRL_UNIPOLAR_BIT] ? w : w ^ 24'h800000);
      @(posedge clk_sys);
      result_data  <= w;
      result_valid <= 1;
      @(posedge clk_sys);
      result_valid <= 0;
      settle();
      check({23'h0, result_ready_n}, 24'h0);
      check({23'h0, irq}, 24'h1);
      rd(OFS_RESULT, res_q[0]);
      ser(1, 1, 24, 24'h0);
      check(v, res_q.pop_front());
      check({23'h0, result_ready_n}, 24'h1);
      wr(OFS_MASK, 24'h0);
      settle();
      check({23'h0, irq}, 24'h0);
      wr(OFS_MASK, 24'hF);
      wr(OFS_STATUS, 24'hF);
      rd(OFS_STATUS, 24'h0);
    end
    w = 24'(oe_cnt);
    ser(1, 1, 24, 24'h0);
    check(24'(oe_cnt), w);
    @(posedge clk_sys);
    cal_done <= 1;
    @(posedge clk_sys);
    cal_done <= 0;
    settle();
    check({23'h0, result_ready_n}, 24'h0);
    rd(OFS_STATUS, 24'h2);
    // calibration register path: non-normal mode, write then read back
    w = {3'h1, 21'($urandom)};
    ser(0, 0, 24, w);
    ser(0, 1, 24, ~w);
    rd(OFS_CALIB, ~w);
    ser(1, 1, 24, 24'h0);
    check(v, ~w);
    ctrl_m = w;
    @(posedge clk_sys);
    standby_n <= 0;
    ser(0, 0, 24, ~ctrl_m);
    rd(OFS_CTRL, ctrl_m);
    @(posedge clk_sys);
    standby_n <= 1;
    clk_mode  <= 1;
    reg_sel   <= 0;
    repeat (10) @(posedge clk_sys);
    hst_u.rsync(0);
    for (int i = 0; i < 24; i++)
    begin
      @(negedge sclk_out);
      v = {v[22:0], bidir_serial_line_out};
    end
    check({23'h0, sclk_oe}, 24'h1);
    hst_u.rsync(1);
    check(v, ctrl_m);
    summarize();
  end

  // watchdog against a hung link
  initial
  begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule // adc_framed_serial_port_tb
